// ### hdl/dcc_top.sv
// Purpose: Control register logic of one DMA channel
// Assumes: Datapath and neighbour channels drive synchronous pulses
// Notes:   Registers reached over AXI4-Lite, one aligned word each
`timescale 1ns/1ps

module dcc_top
    import dcc_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Channel events
    input  wire logic        start_evt,
    input  wire logic        abort_evt,
    // Neighbour completions
    input  wire logic        lower_done,
    input  wire logic        higher_done,
    // Datapath
    input  wire logic        xfer_busy,
    input  wire logic        xfer_last,
    input  wire dcc_byte_s   rd_byte,
    // Channel outputs
    output logic             xfer_enable,
    output logic             channel_active,
    output logic             channel_done
);

    dcc_top_s       s;
    dcc_top_s       next_s;
    dcc_match_cfg_s mcfg;
    logic           pat_hit;
    logic           aw_take;
    logic           w_take;
    logic           ar_take;
    logic           do_wr;
    logic           chain_go;
    logic           evt_ok;
    logic           active;
    logic [31:0]    ctrl_word;
    logic [31:0]    stat_word;
    logic [31:0]    wr_val;

    // Merge write data into an old word by byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Pattern matcher, live only while transferring
    assign mcfg.pattern  = s.pattern;
    assign mcfg.two_byte = s.ctrl.plen;
    assign mcfg.ign_en   = s.ctrl.ign_en;
    assign mcfg.ign_val  = s.ctrl.ign_val;
    assign mcfg.enable   = (s.phase == PH_RUN);

    dcc_match u_match (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cfg     (mcfg),
        .rd_byte (rd_byte),
        .hit     (pat_hit)
    );

    // Active while enabled or still winding down
    assign active = s.ctrl.on || (s.phase != PH_IDLE);

    // Chain source chosen by direction, gated by permit
    assign chain_go = s.ctrl.cperm
                   && (s.ctrl.cdir ? lower_done
                                   : higher_done);

    // Events count when enabled or when allowed while off
    assign evt_ok = s.ctrl.on || s.ctrl.ewo;

    // Bus handshakes
    assign s_axi_awready = !s.aw_held && !s.bvalid;
    assign s_axi_wready  = !s.w_held && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign do_wr         = s.aw_held && s.w_held && !s.bvalid;

    // Readable images; unused bits stay zero
    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[IGN_LSB +: 8] = s.ctrl.ign_val;
        ctrl_word[ACT_BIT]      = active;
        ctrl_word[IGNEN_BIT]    = s.ctrl.ign_en;
        ctrl_word[PLEN_BIT]     = s.ctrl.plen;
        ctrl_word[CDIR_BIT]     = s.ctrl.cdir;
        ctrl_word[ON_BIT]       = s.ctrl.on;
        ctrl_word[EWO_BIT]      = s.ctrl.ewo;
        ctrl_word[CPERM_BIT]    = s.ctrl.cperm;
        stat_word = '0;
        stat_word[ST_START] = s.start_pend;
        stat_word[ST_ABORT] = s.abort_pend;
        stat_word[ST_HIT]   = s.hit_seen;
        stat_word[ST_DONE]  = s.done_seen;
    end

    // Next state: software first, then phase, then hardware sets
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        wr_val = '0;

        // Capture write address and data in either order
        if (aw_take)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (w_take)
        begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end

        // Perform write once both halves are held
        if (do_wr)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            if (s.aw_addr == ADDR_CTRL)
            begin
                wr_val = merge(ctrl_word, s.w_data, s.w_strb);
                // Only implemented fields are kept
                next_s.ctrl.ign_val = wr_val[IGN_LSB +: 8];
                next_s.ctrl.ign_en  = wr_val[IGNEN_BIT];
                next_s.ctrl.plen    = wr_val[PLEN_BIT];
                next_s.ctrl.cdir    = wr_val[CDIR_BIT];
                next_s.ctrl.on      = wr_val[ON_BIT];
                next_s.ctrl.ewo     = wr_val[EWO_BIT];
                next_s.ctrl.cperm   = wr_val[CPERM_BIT];
            end
            else if (s.aw_addr == ADDR_PAT)
            begin
                wr_val = merge({16'h0000, s.pattern}, s.w_data, s.w_strb);
                next_s.pattern = wr_val[15:0];
            end
            else if (s.aw_addr == ADDR_STAT)
            begin
                // Write one to clear
                wr_val = s.w_data & {{28{1'b0}}, s.w_strb[0], s.w_strb[0],
                                     s.w_strb[0], s.w_strb[0]};
                if (wr_val[ST_START])
                begin
                    next_s.start_pend = 1'b0;
                end
                if (wr_val[ST_ABORT])
                begin
                    next_s.abort_pend = 1'b0;
                end
                if (wr_val[ST_HIT])
                begin
                    next_s.hit_seen = 1'b0;
                end
                if (wr_val[ST_DONE])
                begin
                    next_s.done_seen = 1'b0;
                end
            end
            else
            begin
                next_s.bresp = RESP_SLVERR;
            end
        end
        if (s.bvalid && s_axi_bready)
        begin
            next_s.bvalid = 1'b0;
        end

        // Read decode
        if (ar_take)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            if (s_axi_araddr == ADDR_CTRL)
            begin
                next_s.rdata = ctrl_word;
            end
            else if (s_axi_araddr == ADDR_PAT)
            begin
                next_s.rdata = {16'h0000, s.pattern};
            end
            else if (s_axi_araddr == ADDR_STAT)
            begin
                next_s.rdata = stat_word;
            end
            else
            begin
                next_s.rdata = '0;
                next_s.rresp = RESP_SLVERR;
            end
        end
        else if (s.rvalid && s_axi_rready)
        begin
            next_s.rvalid = 1'b0;
        end

        // Channel phase
        case (s.phase)
            PH_IDLE:
            begin
                if (s.abort_pend)
                begin
                    // Abort drops any start still pending
                    next_s.abort_pend = 1'b0;
                    next_s.start_pend = 1'b0;
                end
                else if (s.start_pend && s.ctrl.on && next_s.ctrl.on)
                begin
                    next_s.start_pend = 1'b0;
                    next_s.phase      = PH_RUN;
                end
            end
            PH_RUN:
            begin
                if (!next_s.ctrl.on)
                begin
                    next_s.phase = PH_DRAIN;
                end
                else if (s.abort_pend)
                begin
                    next_s.abort_pend = 1'b0;
                    next_s.ctrl.on    = 1'b0;
                    next_s.phase      = PH_DRAIN;
                end
                else if (pat_hit || xfer_last)
                begin
                    // Block finished or pattern found
                    next_s.ctrl.on = 1'b0;
                    next_s.done    = 1'b1;
                    next_s.phase   = PH_DRAIN;
                end
            end
            PH_DRAIN:
            begin
                // Hold off until the bus transaction ends
                if (!xfer_busy)
                begin
                    next_s.phase = PH_IDLE;
                end
            end
            default:
            begin
                next_s.phase = PH_IDLE;
            end
        endcase

        // Hardware sets win over software clears
        if (pat_hit && s.phase == PH_RUN)
        begin
            next_s.hit_seen = 1'b1;
        end
        if (next_s.done)
        begin
            next_s.done_seen = 1'b1;
        end
        if (start_evt && evt_ok)
        begin
            next_s.start_pend = 1'b1;
        end
        if (abort_evt && evt_ok)
        begin
            next_s.abort_pend = 1'b1;
        end
        if (chain_go)
        begin
            // Chained start enables and starts the channel
            next_s.ctrl.on    = 1'b1;
            next_s.start_pend = 1'b1;
        end
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s                 <= '0;
            s.phase           <= PH_IDLE;
            s.ctrl.ign_val    <= IGN_RST;
            s.pattern         <= PAT_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs
    assign s_axi_bvalid   = s.bvalid;
    assign s_axi_bresp    = s.bresp;
    assign s_axi_rvalid   = s.rvalid;
    assign s_axi_rdata    = s.rdata;
    assign s_axi_rresp    = s.rresp;
    assign xfer_enable    = (s.phase == PH_RUN);
    assign channel_active = active;
    assign channel_done   = s.done;

endmodule : dcc_top

// ### hdl/dcc_pkg.sv
// Purpose: Shared constants and types for the DMA channel control block
// Assumes: 32-bit AXI4-Lite register access, byte addresses in 8 bits
// Notes:   Field positions refer to the channel_control word
package dcc_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PAT  = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;

    // channel_control field positions
    localparam int IGN_LSB   = 24;
    localparam int ACT_BIT   = 15;
    localparam int IGNEN_BIT = 13;
    localparam int PLEN_BIT  = 11;
    localparam int CDIR_BIT  = 8;
    localparam int ON_BIT    = 7;
    localparam int EWO_BIT   = 6;
    localparam int CPERM_BIT = 5;

    // Status register field positions
    localparam int ST_START = 0;
    localparam int ST_ABORT = 1;
    localparam int ST_HIT   = 2;
    localparam int ST_DONE  = 3;

    // Reset values
    localparam logic [7:0]  IGN_RST = 8'h00;
    localparam logic [15:0] PAT_RST = 16'h0000;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Channel phase
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b001,
        PH_RUN   = 3'b010,
        PH_DRAIN = 3'b100
    } dcc_phase_e;

    // Software control fields
    typedef struct packed {
        logic [7:0] ign_val;
        logic       ign_en;
        logic       plen;
        logic       cdir;
        logic       on;
        logic       ewo;
        logic       cperm;
    } dcc_ctrl_s;

    // One byte read by the channel
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } dcc_byte_s;

    // Matcher configuration
    typedef struct packed {
        logic [15:0] pattern;
        logic        two_byte;
        logic        ign_en;
        logic [7:0]  ign_val;
        logic        enable;
    } dcc_match_cfg_s;

    // Matcher state
    typedef struct packed {
        logic [7:0] prev;
        logic       prev_ok;
        logic       hit;
    } dcc_match_s;

    // Top-level state
    typedef struct packed {
        dcc_phase_e  phase;
        dcc_ctrl_s   ctrl;
        logic [15:0] pattern;
        logic        start_pend;
        logic        abort_pend;
        logic        hit_seen;
        logic        done_seen;
        logic        done;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dcc_top_s;

endpackage : dcc_pkg

// ### hdl/dcc_match.sv
// Purpose: Pattern comparison on the byte stream read by the channel
// Assumes: One byte at most per clock, qualified by valid
// Notes:   Hit is a registered one-cycle pulse
`timescale 1ns/1ps
module dcc_match
    import dcc_pkg::*;
(
    // Clock and reset
    input  wire logic           aclk,
    input  wire logic           aresetn,
    // Configuration and stream
    input  wire dcc_match_cfg_s cfg,
    input  wire dcc_byte_s      rd_byte,
    // Result
    output logic                hit
);

    dcc_match_s s;
    dcc_match_s next_s;
    logic       cur_eq;
    logic       old_eq;

    // Byte compare with ignore byte as don't-care
    always_comb
    begin
        cur_eq = (rd_byte.data == cfg.pattern[7:0])
              || (cfg.ign_en && rd_byte.data == cfg.ign_val);
        old_eq = (s.prev == cfg.pattern[15:8])
              || (cfg.ign_en && s.prev == cfg.ign_val);
        next_s = s;
        next_s.hit = 1'b0;
        if (!cfg.enable)
        begin
            next_s.prev_ok = 1'b0;
        end
        else if (rd_byte.valid)
        begin
            // Older byte vs high pattern byte, newest vs low
            if (cfg.two_byte)
            begin
                next_s.hit = cur_eq && old_eq && s.prev_ok;
            end
            else
            begin
                next_s.hit = cur_eq;
            end
            next_s.prev    = rd_byte.data;
            next_s.prev_ok = 1'b1;
        end
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign hit = s.hit;

endmodule : dcc_match

// ### tb/dcc_chk.sv
// Purpose: Port-level assertions for the channel control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into dcc_top after the module
`timescale 1ns/1ps
module dcc_chk
    import dcc_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Channel
    input wire logic        xfer_busy,
    input wire logic        xfer_enable,
    input wire logic        channel_active,
    input wire logic        channel_done
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Write taken in one cycle, then answered with both halves refused
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_resp;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence

    // Bus handshake properties
    property p_wr_resp; s_wr_both |=> !s_axi_awready && !s_axi_wready ##1 s_wr_resp;
    endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    // Channel state properties
    property p_run_act; xfer_enable |-> channel_active; endproperty
    property p_done_pulse; channel_done |=> !channel_done; endproperty
    property p_done_act; channel_done |-> channel_active; endproperty
    property p_drain; $fell(xfer_enable) && xfer_busy |=> channel_active; endproperty

    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    a_b_hold: assert property (p_b_hold) else $error("write response not held");
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    a_run_act: assert property (p_run_act) else $error("running but not active");
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    a_done_act: assert property (p_done_act) else $error("done while inactive");
    a_drain: assert property (p_drain) else $error("active dropped in drain");
endmodule : dcc_chk

bind dcc_top dcc_chk dcc_chk_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .xfer_busy, .xfer_enable, .channel_active, .channel_done);

// ### tb/testbench.sv
// Purpose: Register-level test of the channel control block
// Assumes: 20 MHz clock, AXI4-Lite master driven on rising edges
// Notes:   Watchdog ends the run if a handshake hangs
`timescale 1ns/1ps
module testbench
    import dcc_pkg::*;
;
    // Driven inputs
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        start_evt = 1'b0, abort_evt = 1'b0, lower_done = 1'b0, higher_done = 1'b0;
    logic        xfer_busy = 1'b0, xfer_last = 1'b0;
    dcc_byte_s   rd_byte = '0;
    // Observed outputs
    wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic        xfer_enable, channel_active, channel_done;
    // Bookkeeping
    int          errors = 0, checks = 0;
    logic [31:0] rd;
    logic [1:0]  rs;
    // Control word fields
    localparam logic [31:0] C_ON = 32'h1 << ON_BIT, C_EWO = 32'h1 << EWO_BIT;
    localparam logic [31:0] C_PRM = 32'h1 << CPERM_BIT, C_DIR = 32'h1 << CDIR_BIT;
    localparam logic [31:0] C_PLN = 32'h1 << PLEN_BIT, C_IGN = 32'h1 << IGNEN_BIT;
    localparam logic [31:0] C_ACT = 32'h1 << ACT_BIT, C_IV = 32'h55 << IGN_LSB;
    // Chain cases: control, event {start,abort,lower,higher}, run expected
    logic [31:0] cc [5] = '{C_PRM | C_DIR, C_PRM | C_DIR, C_DIR, C_PRM, C_PRM};
    logic [3:0]  ce [5] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h1};
    logic [31:0] cr [5] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h1};
    // Match cases: control, pattern, two bytes, hit expected
    logic [31:0] pc [5] = '{C_ON, C_ON | C_PLN, C_ON | C_PLN, C_ON | C_PLN | C_IGN | C_IV,
                            C_ON | C_PLN | C_IV};
    logic [15:0] pp [5] = '{16'h0041, 16'h4142, 16'h4142, 16'h4142, 16'h4142};
    logic [7:0]  p0 [5] = '{8'h00, 8'h41, 8'h42, 8'h41, 8'h41};
    logic [7:0]  p1 [5] = '{8'h41, 8'h42, 8'h41, 8'h55, 8'h55};
    logic [31:0] ph [5] = '{32'h1, 32'h1, 32'h0, 32'h1, 32'h0};

    dcc_top dcc_top_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .start_evt, .abort_evt,
        .lower_done, .higher_done, .xfer_busy, .xfer_last, .rd_byte, .xfer_enable,
        .channel_active, .channel_done);

    // Clock
    initial
    begin
        forever #25 aclk = ~aclk;
    end

    // Verdict and end of run
    task automatic print_verdict();
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // Compare one word
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk

    // Write one word and take the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    // Read one word and its response
    task automatic rdw(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rdw

    // One-cycle event pulse, then time for the channel to react
    task automatic ev(input logic [3:0] m);
        {start_evt, abort_evt, lower_done, higher_done} <= m;
        @(posedge aclk);
        {start_evt, abort_evt, lower_done, higher_done} <= 4'h0;
        repeat (3) @(posedge aclk);
    endtask : ev

    // One byte read by the channel, data scrambled when not valid
    task automatic byt(input logic [7:0] b);
        rd_byte <= '{valid: 1'b1, data: b};
        @(posedge aclk);
        rd_byte <= '{valid: 1'b0, data: ~b};
        @(posedge aclk);
    endtask : byt

    // Main sequence
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdw(ADDR_CTRL);
        chk("ctrl reset", 32'h0, rd);
        wr(ADDR_CTRL, 32'hffff_ffff);
        chk("ctrl bresp", 32'(RESP_OKAY), 32'(rs));
        rdw(ADDR_CTRL);
        chk("ctrl ones", 32'hff00_a9e0, rd);
        wr(ADDR_CTRL, 32'h0);
        rdw(ADDR_CTRL);
        chk("ctrl zero", 32'h0, rd);
        wr(8'h0c, 32'hffff_ffff);
        chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rs));
        rdw(8'h0c);
        chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rs));
        chk("unmapped data", 32'h0, rd);
        // Start while off, with and without keeping events
        ev(4'h8);
        rdw(ADDR_STAT);
        chk("start dropped", 32'h0, rd);
        wr(ADDR_CTRL, C_EWO);
        ev(4'h8);
        rdw(ADDR_STAT);
        chk("start kept", 32'h1 << ST_START, rd);
        wr(ADDR_STAT, 32'hf);
        // Chained starts by source and permission
        for (int i = 0; i < 5; i++)
        begin
            wr(ADDR_CTRL, cc[i]);
            ev(ce[i]);
            chk("chain run", cr[i], 32'(xfer_enable));
            wr(ADDR_CTRL, 32'h0);
            wr(ADDR_STAT, 32'hf);
        end
        // Suspend with a bus transaction in flight
        wr(ADDR_CTRL, C_ON);
        ev(4'h8);
        xfer_busy <= 1'b1;
        @(posedge aclk);
        wr(ADDR_CTRL, 32'h0);
        chk("drain active", 32'h1, 32'(channel_active));
        chk("drain enable", 32'h0, 32'(xfer_enable));
        rdw(ADDR_CTRL);
        chk("drain status", C_ACT, rd);
        xfer_busy <= 1'b0;
        repeat (3) @(posedge aclk);
        rdw(ADDR_CTRL);
        chk("suspended", 32'h0, rd);
        wr(ADDR_STAT, 32'hf);
        // Pattern length and ignore byte
        for (int i = 0; i < 5; i++)
        begin
            wr(ADDR_PAT, {16'h0, pp[i]});
            wr(ADDR_CTRL, pc[i]);
            ev(4'h8);
            byt(p0[i]);
            byt(p1[i]);
            repeat (3) @(posedge aclk);
            chk("run after bytes", 32'(ph[i] == 32'h0), 32'(xfer_enable));
            rdw(ADDR_STAT);
            chk("hit", ph[i], 32'(rd[ST_HIT]));
            chk("done", ph[i], 32'(rd[ST_DONE]));
            wr(ADDR_CTRL, 32'h0);
            wr(ADDR_STAT, 32'hf);
        end
        // Abort while running stops the channel and clears enable
        wr(ADDR_CTRL, C_ON);
        ev(4'h8);
        ev(4'h4);
        chk("abort run", 32'h0, 32'(xfer_enable));
        rdw(ADDR_CTRL);
        chk("abort ctrl", 32'h0, rd);
        // Block end from the datapath gives a one-cycle done pulse
        wr(ADDR_CTRL, C_ON);
        ev(4'h8);
        xfer_last <= 1'b1;
        @(posedge aclk);
        xfer_last <= 1'b0;
        @(posedge aclk);
        chk("done pulse", 32'h1, 32'(channel_done));
        @(posedge aclk);
        chk("done end", 32'h0, 32'(channel_done));
        rdw(ADDR_STAT);
        chk("done seen", 32'h1 << ST_DONE, rd);
        print_verdict();
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        print_verdict();
    end
endmodule : testbench
